// File: rtl/gpfp_pkg.sv
// Package: register map, field layout, reset values and pin modes
package gpfp_pkg;
  localparam int unsigned PIN_W = 8;
  localparam int unsigned INT_SEL_W = 3;

  localparam logic [31:0] OFS_PORT_VALUE = 32'h800000a0;
  localparam logic [31:0] OFS_PORT_DIRECTION = 32'h800000a4;
  localparam logic [31:0] OFS_PORT_INT_SETUP = 32'h800000a8;
  localparam logic [31:0] OFS_SYSTEM_CONTROL = 32'h800000ac;

  localparam int unsigned INT_SEL_LSB = 0;
  localparam int unsigned INT_POL_BIT = 5;
  localparam int unsigned INT_TRIG_BIT = 6;
  localparam int unsigned INT_EN_BIT = 7;
  localparam int unsigned INT_B_SHIFT = 8;
  localparam logic [15:0] INT_SETUP_MASK = 16'he7e7;

  localparam int unsigned SYSCTL_SEL_LSB = 0;
  localparam int unsigned SYSCTL_ROW_BIT = 3;

  localparam logic [7:0] RST_PORT_VALUE = 8'h00;
  localparam logic [7:0] RST_PORT_DIRECTION = 8'h00;
  localparam logic [15:0] RST_PORT_INT_SETUP = 16'h0000;
  localparam logic [2:0] RST_PIN_FUNCTION = 3'h0;
  localparam logic RST_SLAVE_ROW = 1'b0;

  typedef enum logic [2:0] {
    GPFP_MODE_PIO = 3'b000,
    GPFP_MODE_UART = 3'b001,
    GPFP_MODE_SPI_UART = 3'b010,
    GPFP_MODE_SPI_PULSE = 3'b011,
    GPFP_MODE_MEAS = 3'b100,
    GPFP_MODE_EXTBUS = 3'b101,
    GPFP_MODE_DEBUG = 3'b110,
    GPFP_MODE_PROFILE = 3'b111
  } gpfp_mode_e;
endpackage

// File: rtl/gpfp_reg_if.sv
// Interface: register access between bus slave and register file
`timescale 1ns/1ps
interface gpfp_reg_if;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [3:0] be;
  logic wr_en;
  logic [31:0] rdata;

  modport bus (output addr, output wdata, output be, output wr_en,
    input rdata);
  modport regs (input addr, input wdata, input be, input wr_en,
    output rdata);
endinterface

// File: rtl/gpfp_wb_slave.sv
// Classic Wishbone slave, one wait state, registered read data
`timescale 1ns/1ps
module gpfp_wb_slave
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  gpfp_reg_if.bus rif
);
  import gpfp_pkg::*;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } gpfp_wbs_s;

  gpfp_wbs_s s_r;
  gpfp_wbs_s s_nxt;
  logic req;

  assign req = wb_cyc_i & wb_stb_i;
  assign rif.addr = wb_adr_i;
  assign rif.wdata = wb_dat_i;
  assign rif.be = wb_sel_i;
  // Write lands on the edge where the master sees ack
  assign rif.wr_en = s_r.ack & req & wb_we_i;
  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = s_r.dat;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.ack = req & ~s_r.ack;
    if (req & ~s_r.ack)
    begin
      s_nxt.dat = wb_we_i ? 32'h0000_0000 : rif.rdata;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end
endmodule

// File: rtl/gpfp_int_qual.sv
// One port interrupt: pin pick, polarity and level or edge qualifier
`timescale 1ns/1ps
module gpfp_int_qual
#(
  parameter int unsigned PINS = 8,
  parameter int unsigned SEL_W = 3
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [PINS-1:0] pins_i,
  input wire logic enable_i,
  input wire logic edge_i,
  input wire logic active_high_i,
  input wire logic [SEL_W-1:0] pin_sel_i,
  output logic irq_o
);
  import gpfp_pkg::*;

  if (PINS != (1 << SEL_W))
  begin : g_check
    $error("gpfp_int_qual: PINS must equal 2**SEL_W");
  end

  typedef struct packed {
    logic prev;
    logic irq;
  } gpfp_iq_s;

  gpfp_iq_s s_r;
  gpfp_iq_s s_nxt;
  logic active;

  always_comb
  begin
    s_nxt = s_r;
    active = active_high_i ? pins_i[pin_sel_i] : ~pins_i[pin_sel_i];
    s_nxt.prev = active;
    // Edge mode gives a one-cycle pulse on the inactive-to-active step
    s_nxt.irq = enable_i & (edge_i ? (active & ~s_r.prev) : active);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign irq_o = s_r.irq;
endmodule

// File: rtl/gpfp_port.sv
// Top: shared pin function port with parallel I/O registers
`timescale 1ns/1ps
module gpfp_port
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [gpfp_pkg::PIN_W-1:0] pin_i,
  output logic [gpfp_pkg::PIN_W-1:0] pin_o,
  output logic [gpfp_pkg::PIN_W-1:0] pin_oe_o,
  input wire logic second_serial_tx_i,
  output logic second_serial_rx_o,
  input wire logic [1:0] serial_master_slave_select_i,
  input wire logic spi_master_mosi_i,
  input wire logic spi_master_clk_i,
  output logic spi_master_miso_o,
  input wire logic spi_slave_miso_i,
  output logic spi_slave_select_low_o,
  output logic spi_slave_mosi_o,
  output logic spi_slave_clk_o,
  input wire logic pulse_valid_i,
  input wire logic time_pulse_i,
  input wire logic acc_int_i,
  input wire logic meas_int_i,
  input wire logic bus_chip_select_three_i,
  output logic bus_ready_low_o,
  output logic bus_exception_low_o,
  input wire logic demodulator_probe_i,
  input wire logic sysbus_ready_probe_i,
  input wire logic onchip_ram_select_probe_i,
  input wire logic scratchpad_select_probe_i,
  input wire logic cpu_error_probe_i,
  input wire logic icache_hit_probe_i,
  input wire logic [3:0] interrupt_probe_i,
  input wire logic int_ack_probe_i,
  input wire logic supervisor_probe_i,
  output logic port_int_a_o,
  output logic port_int_b_o
);
  import gpfp_pkg::*;

  typedef struct packed {
    logic [PIN_W-1:0] value;
    logic [PIN_W-1:0] direction;
    logic [15:0] int_setup;
    logic [2:0] pin_function_select;
    logic slave_row;
    logic [PIN_W-1:0] pin_level;
    logic [PIN_W-1:0] pin_out;
    logic [PIN_W-1:0] pin_oe;
    logic rx;
    logic spi_miso;
    logic spis_ssn;
    logic spis_mosi;
    logic spis_clk;
    logic brdy_n;
    logic bexc_n;
  } gpfp_port_s;

  gpfp_port_s s_r;
  gpfp_port_s s_nxt;
  gpfp_reg_if rif ();
  gpfp_mode_e mode;
  logic [PIN_W-1:0] pio_mask;
  logic [PIN_W-1:0] alt_out;
  logic [PIN_W-1:0] alt_oe;

  // Byte-lane merge used by the value, direction and interrupt setup writes
  function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
    input logic [7:0] new_v, input logic lane);
    merge_byte = lane ? new_v : old_v;
  endfunction

  // Pins left to the parallel port in each function code
  function automatic logic [PIN_W-1:0] pio_pins(input gpfp_mode_e m);
    unique case (m)
      GPFP_MODE_PIO: pio_pins = 8'hff;
      GPFP_MODE_UART: pio_pins = 8'h3f;
      GPFP_MODE_SPI_UART: pio_pins = 8'h01;
      GPFP_MODE_SPI_PULSE: pio_pins = 8'h01;
      GPFP_MODE_MEAS: pio_pins = 8'h03;
      GPFP_MODE_EXTBUS: pio_pins = 8'h03;
      GPFP_MODE_DEBUG: pio_pins = 8'h03;
      GPFP_MODE_PROFILE: pio_pins = 8'h00;
    endcase
  endfunction

  gpfp_wb_slave u_bus (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .rif(rif.bus)
  );

  assign mode = gpfp_mode_e'(s_r.pin_function_select);

  // Register read; unmapped addresses read as zero
  always_comb
  begin
    if (rif.addr == OFS_PORT_VALUE)
    begin
      rif.rdata = {24'h000000, s_r.pin_level};
    end
    else if (rif.addr == OFS_PORT_DIRECTION)
    begin
      rif.rdata = {24'h000000, s_r.direction};
    end
    else if (rif.addr == OFS_PORT_INT_SETUP)
    begin
      rif.rdata = {16'h0000, s_r.int_setup};
    end
    else if (rif.addr == OFS_SYSTEM_CONTROL)
    begin
      rif.rdata = {28'h0000000, s_r.slave_row, s_r.pin_function_select};
    end
    else
    begin
      rif.rdata = 32'h0000_0000;
    end
  end

  // Alternate-function drive per pin, by function code
  always_comb
  begin
    alt_out = '0;
    alt_oe = '0;
    unique case (mode)
      GPFP_MODE_PIO:
      begin
        alt_oe = '0;
      end
      GPFP_MODE_UART:
      begin
        alt_out[6] = second_serial_tx_i;
        alt_oe[6] = 1'b1;
      end
      GPFP_MODE_SPI_UART, GPFP_MODE_SPI_PULSE:
      begin
        if (s_r.slave_row)
        begin
          // Slave row: select, mosi and clock are inputs; pin 2 idle
          alt_out[4] = spi_slave_miso_i;
          alt_oe[4] = 1'b1;
          alt_out[6] = second_serial_tx_i;
          alt_oe[6] = 1'b1;
        end
        else
        begin
          alt_out[2:1] = serial_master_slave_select_i;
          alt_out[4] = spi_master_mosi_i;
          alt_out[5] = spi_master_clk_i;
          // Pin 3 stays an input: it carries the master's receive line
          alt_oe[5:1] = 5'b11011;
          if (mode == GPFP_MODE_SPI_PULSE)
          begin
            alt_out[6] = pulse_valid_i;
            alt_out[7] = time_pulse_i;
            alt_oe[7:6] = 2'b11;
          end
          else
          begin
            alt_out[6] = second_serial_tx_i;
            alt_oe[6] = 1'b1;
          end
        end
      end
      GPFP_MODE_MEAS:
      begin
        alt_out[5:2] = {time_pulse_i, pulse_valid_i, meas_int_i,
          acc_int_i};
        alt_oe[5:2] = 4'hf;
        alt_out[6] = second_serial_tx_i;
        alt_oe[6] = 1'b1;
      end
      GPFP_MODE_EXTBUS:
      begin
        alt_out[2] = bus_chip_select_three_i;
        alt_oe[2] = 1'b1;
        alt_out[5] = time_pulse_i;
        alt_oe[5] = 1'b1;
        alt_out[6] = second_serial_tx_i;
        alt_oe[6] = 1'b1;
      end
      GPFP_MODE_DEBUG:
      begin
        alt_out[7:2] = {icache_hit_probe_i, cpu_error_probe_i,
          scratchpad_select_probe_i, onchip_ram_select_probe_i,
          sysbus_ready_probe_i, demodulator_probe_i};
        alt_oe[7:2] = 6'h3f;
      end
      GPFP_MODE_PROFILE:
      begin
        alt_out = {acc_int_i, supervisor_probe_i, int_ack_probe_i,
          meas_int_i, interrupt_probe_i};
        alt_oe = 8'hff;
      end
    endcase
  end

  always_comb
  begin
    s_nxt = s_r;
    pio_mask = pio_pins(mode);
    s_nxt.pin_level = pin_i;

    if (rif.wr_en)
    begin
      if (rif.addr == OFS_PORT_VALUE)
      begin
        s_nxt.value = merge_byte(s_r.value, rif.wdata[7:0], rif.be[0]);
      end
      if (rif.addr == OFS_PORT_DIRECTION)
      begin
        s_nxt.direction = merge_byte(s_r.direction, rif.wdata[7:0],
          rif.be[0]);
      end
      if (rif.addr == OFS_PORT_INT_SETUP)
      begin
        s_nxt.int_setup[7:0] = merge_byte(s_r.int_setup[7:0],
          rif.wdata[7:0] & INT_SETUP_MASK[7:0], rif.be[0]);
        s_nxt.int_setup[15:8] = merge_byte(s_r.int_setup[15:8],
          rif.wdata[15:8] & INT_SETUP_MASK[15:8], rif.be[1]);
      end
      if ((rif.addr == OFS_SYSTEM_CONTROL) && rif.be[0])
      begin
        s_nxt.pin_function_select =
          rif.wdata[SYSCTL_SEL_LSB +: 3];
        s_nxt.slave_row = rif.wdata[SYSCTL_ROW_BIT];
      end
    end

    // Port bits only reach pins the current code leaves to the port
    s_nxt.pin_out = (s_r.value & pio_mask) | (alt_out & ~pio_mask);
    s_nxt.pin_oe = (s_r.direction & pio_mask) |
      (alt_oe & ~pio_mask);

    // Alternate inputs sit at their idle level unless routed
    s_nxt.rx = 1'b1;
    s_nxt.spi_miso = 1'b0;
    s_nxt.spis_ssn = 1'b1;
    s_nxt.spis_mosi = 1'b0;
    s_nxt.spis_clk = 1'b0;
    s_nxt.brdy_n = 1'b1;
    s_nxt.bexc_n = 1'b1;
    if ((mode != GPFP_MODE_PIO) && (mode != GPFP_MODE_PROFILE) &&
      (mode != GPFP_MODE_DEBUG))
    begin
      if (!((mode == GPFP_MODE_SPI_PULSE) && !s_r.slave_row))
      begin
        s_nxt.rx = pin_i[7];
      end
    end
    if ((mode == GPFP_MODE_SPI_UART) || (mode == GPFP_MODE_SPI_PULSE))
    begin
      if (s_r.slave_row)
      begin
        s_nxt.spis_ssn = pin_i[1];
        s_nxt.spis_mosi = pin_i[3];
        s_nxt.spis_clk = pin_i[5];
      end
      else
      begin
        s_nxt.spi_miso = pin_i[3];
      end
    end
    if (mode == GPFP_MODE_EXTBUS)
    begin
      s_nxt.brdy_n = pin_i[3];
      s_nxt.bexc_n = pin_i[4];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_r.value <= RST_PORT_VALUE;
      s_r.direction <= RST_PORT_DIRECTION;
      s_r.int_setup <= RST_PORT_INT_SETUP;
      s_r.pin_function_select <= RST_PIN_FUNCTION;
      s_r.slave_row <= RST_SLAVE_ROW;
      s_r.pin_level <= '0;
      s_r.pin_out <= '0;
      s_r.pin_oe <= '0;
      s_r.rx <= 1'b1;
      s_r.spi_miso <= 1'b0;
      s_r.spis_ssn <= 1'b1;
      s_r.spis_mosi <= 1'b0;
      s_r.spis_clk <= 1'b0;
      s_r.brdy_n <= 1'b1;
      s_r.bexc_n <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // Sources sample registered pin levels, so two cycles of latency from pin to interrupt
  gpfp_int_qual #(.PINS(PIN_W), .SEL_W(INT_SEL_W)) u_int_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pins_i(s_r.pin_level),
    .enable_i(s_r.int_setup[INT_EN_BIT]),
    .edge_i(s_r.int_setup[INT_TRIG_BIT]),
    .active_high_i(s_r.int_setup[INT_POL_BIT]),
    .pin_sel_i(s_r.int_setup[INT_SEL_LSB +: INT_SEL_W]),
    .irq_o(port_int_a_o)
  );

  gpfp_int_qual #(.PINS(PIN_W), .SEL_W(INT_SEL_W)) u_int_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pins_i(s_r.pin_level),
    .enable_i(s_r.int_setup[INT_B_SHIFT + INT_EN_BIT]),
    .edge_i(s_r.int_setup[INT_B_SHIFT + INT_TRIG_BIT]),
    .active_high_i(s_r.int_setup[INT_B_SHIFT + INT_POL_BIT]),
    .pin_sel_i(s_r.int_setup[INT_B_SHIFT + INT_SEL_LSB +: INT_SEL_W]),
    .irq_o(port_int_b_o)
  );

  assign pin_o = s_r.pin_out;
  assign pin_oe_o = s_r.pin_oe;
  assign second_serial_rx_o = s_r.rx;
  assign spi_master_miso_o = s_r.spi_miso;
  assign spi_slave_select_low_o = s_r.spis_ssn;
  assign spi_slave_mosi_o = s_r.spis_mosi;
  assign spi_slave_clk_o = s_r.spis_clk;
  assign bus_ready_low_o = s_r.brdy_n;
  assign bus_exception_low_o = s_r.bexc_n;
endmodule

// File: dv/gpfp_pin_model.sv
// External devices wired to the eight shared pins
`timescale 1ns/1ps
module gpfp_pin_model
(
  input wire logic [7:0] drive_i,
  input wire logic [7:0] drive_en_i,
  input wire logic [7:0] ext_i,
  output logic [7:0] level_o
);
  // Outside parts drive every pin the port leaves free, never float it
  assign level_o = (drive_en_i & drive_i) | (~drive_en_i & ext_i);
endmodule

// File: dv/gpfp_port_monitor.sv
// Checker: bus handshake, pin routing and port interrupt relations
`timescale 1ns/1ps
module gpfp_port_monitor
  import gpfp_pkg::*;
(
  input wire logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o,
  input wire logic [31:0] wb_adr_i, wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [7:0] pin_i, pin_o, pin_oe_o,
  input wire logic second_serial_tx_i, second_serial_rx_o,
  input wire logic demodulator_probe_i, sysbus_ready_probe_i,
  input wire logic onchip_ram_select_probe_i, scratchpad_select_probe_i,
  input wire logic cpu_error_probe_i, icache_hit_probe_i,
  input wire logic [3:0] interrupt_probe_i,
  input wire logic int_ack_probe_i, supervisor_probe_i, acc_int_i,
  input wire logic meas_int_i, port_int_a_o, port_int_b_o
);
  typedef struct packed {
    logic [2:0] mode;
    logic row;
    logic [7:0] dir;
    logic [7:0] val;
    logic [15:0] isu;
    logic [1:0] settle;
  } gpfp_mon_s;
  gpfp_mon_s st_r, st_nxt;
  logic [5:0] dbg;
  logic [7:0] prof;
  logic uart_m, src_a;
  assign dbg = {icache_hit_probe_i, cpu_error_probe_i,
    scratchpad_select_probe_i, onchip_ram_select_probe_i,
    sysbus_ready_probe_i, demodulator_probe_i};
  assign prof = {acc_int_i, supervisor_probe_i, int_ack_probe_i,
    meas_int_i, interrupt_probe_i};
  assign uart_m = st_r.mode inside {3'h1, 3'h2, 3'h4, 3'h5} ||
    (st_r.mode == 3'h3 && st_r.row);
  assign src_a = pin_i[st_r.isu[2:0]];
  // Shadow of the registers; settle hides the write-to-pin latency
  always_comb
  begin
    st_nxt = st_r;
    if (st_r.settle != 2'h3)
      st_nxt.settle = st_r.settle + 2'h1;
    if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o)
    begin
      st_nxt.settle = 2'h0;
      if (wb_adr_i == OFS_SYSTEM_CONTROL && wb_sel_i[0])
        {st_nxt.row, st_nxt.mode} = wb_dat_i[3:0];
      if (wb_adr_i == OFS_PORT_DIRECTION && wb_sel_i[0])
        st_nxt.dir = wb_dat_i[7:0];
      if (wb_adr_i == OFS_PORT_VALUE && wb_sel_i[0])
        st_nxt.val = wb_dat_i[7:0];
      if (wb_adr_i == OFS_PORT_INT_SETUP && wb_sel_i[0])
        st_nxt.isu[7:0] = wb_dat_i[7:0] & INT_SETUP_MASK[7:0];
      if (wb_adr_i == OFS_PORT_INT_SETUP && wb_sel_i[1])
        st_nxt.isu[15:8] = wb_dat_i[15:8] & INT_SETUP_MASK[15:8];
    end
  end
  always_ff @(posedge clk_i)
    if (rst_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_RST_OUT: assert property ($fell(rst_i) |-> pin_oe_o == 8'h00
    && second_serial_rx_o) else $error("pins driven after reset");
  AST_PIO: assert property (st_r.settle == 2'h3 &&
    st_r.mode == 3'h0 |-> pin_oe_o == st_r.dir &&
    ((pin_o ^ st_r.val) & st_r.dir) == 8'h00) else $error("port drive");
  AST_DBG: assert property (st_r.settle == 2'h3 &&
    st_r.mode == 3'h6 && $past(dbg) == $past(dbg, 2) |->
    pin_oe_o[7:2] == 6'h3f && pin_o[7:2] == $past(dbg))
    else $error("debug probe routing");
  AST_PROF: assert property (st_r.settle == 2'h3 &&
    st_r.mode == 3'h7 && $past(prof) == $past(prof, 2) |->
    pin_oe_o == 8'hff && pin_o == $past(prof))
    else $error("profile probe routing");
  AST_TX: assert property (st_r.settle == 2'h3 && uart_m &&
    $past(second_serial_tx_i) == $past(second_serial_tx_i, 2) |->
    pin_oe_o[6] && pin_o[6] == $past(second_serial_tx_i))
    else $error("serial transmit routing");
  AST_RX: assert property (st_r.settle == 2'h3 && uart_m |->
    second_serial_rx_o == $past(pin_i[7])) else $error("serial rx");
  AST_IRQ_LVL: assert property (st_r.settle == 2'h3 &&
    st_r.isu[7] && !st_r.isu[6] |->
    port_int_a_o == (st_r.isu[5] ~^ $past(src_a, 2)))
    else $error("level interrupt");
  AST_IRQ_EDGE: assert property (st_r.settle == 2'h3 &&
    st_r.isu[14] && port_int_b_o |=> !port_int_b_o)
    else $error("edge interrupt not a pulse");
  AST_IRQ_OFF: assert property (st_r.settle == 2'h3 &&
    !st_r.isu[15] |-> !port_int_b_o) else $error("disabled interrupt");
  COV_PROF: cover property (st_r.settle == 2'h3 && st_r.mode == 3'h7);
  COV_IRQ: cover property (port_int_a_o);
  COV_READ: cover property (wb_ack_o && !wb_we_i);
endmodule

bind gpfp_port gpfp_port_monitor gpfp_port_monitor_i (.*);

// File: dv/gpfp_port_tb_top.sv
// Testbench: registers, pin routing per mode, port interrupts
`timescale 1ns/1ps
module gpfp_port_tb_top;
  import gpfp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [31:0] wb_adr_i = '0;
  logic [31:0] wb_dat_i = '0;
  logic [3:0] wb_sel_i = '0;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, port_int_a_o, port_int_b_o;
  logic [7:0] pin_i, pin_o, pin_oe_o;
  logic [7:0] ext = '0;
  logic [22:0] s = '0;
  logic [6:0] alt;
  logic [31:0] rq[$];
  int num_errors = 0;
  int n_checks = 0;
  int seed = 32'hd1ba;
  int cycles = 0;
  gpfp_port gpfp_port_i (.*, .second_serial_tx_i(s[0]),
    .serial_master_slave_select_i(s[2:1]), .spi_master_mosi_i(s[3]),
    .spi_master_clk_i(s[4]), .spi_slave_miso_i(s[5]),
    .pulse_valid_i(s[6]), .time_pulse_i(s[7]), .acc_int_i(s[8]),
    .meas_int_i(s[9]), .bus_chip_select_three_i(s[10]),
    .demodulator_probe_i(s[11]), .sysbus_ready_probe_i(s[12]),
    .onchip_ram_select_probe_i(s[13]), .scratchpad_select_probe_i(s[14]),
    .cpu_error_probe_i(s[15]), .icache_hit_probe_i(s[16]),
    .interrupt_probe_i(s[20:17]), .int_ack_probe_i(s[21]),
    .supervisor_probe_i(s[22]), .second_serial_rx_o(alt[0]),
    .spi_master_miso_o(alt[1]), .spi_slave_select_low_o(alt[2]),
    .spi_slave_mosi_o(alt[3]), .spi_slave_clk_o(alt[4]),
    .bus_ready_low_o(alt[5]), .bus_exception_low_o(alt[6]));
  gpfp_pin_model gpfp_pin_model_i (.drive_i(pin_o), .drive_en_i(pin_oe_o),
    .ext_i(ext), .level_o(pin_i));
  always #10 clk_i = ~clk_i;
  task automatic report_and_stop();
    if (num_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic [31:0] a, input logic [31:0] d,
    input logic we);
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_we_i <= we;
    wb_sel_i <= 4'hf;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Expected data is queued before the request, checked at the ack edge
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    rq.push_back(e);
    wb(a, 32'h0, 1'b0);
  endtask
  always @(posedge clk_i)
    if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i && rq.size() > 0)
      cmp(wb_dat_o, rq.pop_front());
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      report_and_stop();
    end
  end
  // Returns {port pin mask, alternate enables, alternate drive}
  function automatic logic [23:0] emap(input logic [3:0] m,
    input logic [22:0] v);
    logic [7:0] pm, e, o;
    pm = 8'h03;
    e = 8'h40;
    o = {1'b0, v[0], 6'h00};
    case (m[2:0])
      3'h0: pm = 8'hff;
      3'h1: pm = 8'h3f;
      3'h2, 3'h3:
      begin
        pm = 8'h01;
        e = m[3] ? 8'h50 : 8'h76;
        o[5:1] = m[3] ? {1'b0, v[5], 3'h0} : {v[4:3], 1'b0, v[2:1]};
        if (m == 4'h3)
        begin
          e = 8'hf6;
          o[7:6] = v[7:6];
        end
      end
      3'h4:
      begin
        e = 8'h7c;
        o[5:2] = {v[7:6], v[9:8]};
      end
      3'h5:
      begin
        e = 8'h64;
        o[5:2] = {v[7], 2'h0, v[10]};
      end
      3'h6:
      begin
        e = 8'hfc;
        o[7:2] = v[16:11];
      end
      default:
      begin
        pm = 8'h00;
        e = 8'hff;
        o = {v[8], v[22:21], v[9], v[20:17]};
      end
    endcase
    if (m[2:0] == 3'h0)
      e = 8'h00;
    return {pm, e, o};
  endfunction
  function automatic logic [6:0] ealt(input logic [3:0] m,
    input logic [7:0] p);
    logic u, ms, sl, b;
    ms = m[2:0] == 3'h2 || m[2:0] == 3'h3;
    sl = ms && m[3];
    ms = ms && !m[3];
    u = m[2:0] inside {3'h1, 3'h2, 3'h4, 3'h5} || m == 4'hb;
    b = m[2:0] == 3'h5;
    return {b ? p[4] : 1'b1, b ? p[3] : 1'b1, sl & p[5], sl & p[3],
      sl ? p[1] : 1'b1, ms & p[3], u ? p[7] : 1'b1};
  endfunction
  initial
  begin
    logic [23:0] x;
    logic [7:0] d, v, e, o, r, p;
    logic [31:0] w;
    logic [2:0] k;
    int n, q;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(OFS_PORT_DIRECTION, 32'h0);
    rd(OFS_PORT_INT_SETUP, 32'h0);
    wb(OFS_PORT_INT_SETUP, 32'hffffffff, 1'b1);
    rd(OFS_PORT_INT_SETUP, 32'h0000e7e7);
    rd(32'h800000b0, 32'h0);
    for (int m = 0; m < 16; m++)
      if (m < 8 || m[2:1] == 2'b01)
      begin
        d = 8'($random(seed));
        v = 8'($random(seed));
        wb(OFS_PORT_DIRECTION, {24'h0, d}, 1'b1);
        wb(OFS_PORT_VALUE, {24'h0, v}, 1'b1);
        wb(OFS_SYSTEM_CONTROL, 32'(m), 1'b1);
        // Reserved slave-row pin has no defined drive
        r = (m > 8) ? 8'h04 : 8'h00;
        repeat (3)
        begin
          s <= 23'($random(seed));
          ext <= 8'($random(seed));
          repeat (4) @(posedge clk_i);
          x = emap(4'(m), s);
          e = (x[15:8] & ~x[23:16]) | (d & x[23:16]);
          o = (x[7:0] & ~x[23:16]) | (v & x[23:16]);
          p = (e & o) | (~e & ext);
          cmp(pin_oe_o & ~r, e & ~r);
          cmp(pin_o & e, o & e);
          cmp(alt, ealt(4'(m), p));
          if (r == 8'h00)
            rd(OFS_PORT_VALUE, {24'h0, p});
        end
      end
    wb(OFS_SYSTEM_CONTROL, 32'h0, 1'b1);
    wb(OFS_PORT_DIRECTION, 32'h0, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      k = 3'($random(seed));
      w = {24'h0, 1'b1, i[2], i[0], 2'h0, k};
      wb(OFS_PORT_INT_SETUP, i[1] ? w << 8 : w, 1'b1);
      ext[k] <= ~i[0];
      repeat (4) @(posedge clk_i);
      ext[k] <= i[0];
      n = 0;
      q = 0;
      repeat (6)
      begin
        @(posedge clk_i);
        if ((i[1] ? port_int_b_o : port_int_a_o) === 1'b1)
          n++;
        if ((i[1] ? port_int_a_o : port_int_b_o) !== 1'b0)
          q++;
      end
      cmp(32'(n), i[2] ? 32'h1 : 32'h4);
      cmp(32'(q), 32'h0);
    end
    report_and_stop();
  end
endmodule
